// *** include/lfrc_pkg.sv ***
package lfrc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_PTR = 8'h08;
  localparam logic [7:0] OFF_ERR = 8'h0C;
  // control register field positions and reset value
  localparam int CTRL_LINK_DOWN = 0;
  localparam int CTRL_RX_INIT = 1;
  localparam int CTRL_RX_RDY = 2;
  localparam int CTRL_SEND = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  // error code posted when the link reset sabm is taken by the transmitter while reset wait is set
  localparam logic [7:0] ERR_FRMR_RX = 8'hC0;
  // timer default in clk cycles, retry default in polls, timer counter width
  localparam int T1_DEFAULT_CYCLES = 2000;
  localparam int N2_DEFAULT = 10;
  localparam int T1_W = 20;
  // frame kinds seen by the receiver and asked of the transmitter
  typedef enum logic [3:0] {
    FR_I = 4'h0, FR_RR = 4'h1, FR_RNR = 4'h2, FR_REJ = 4'h3, FR_SABM = 4'h4,
    FR_DISC = 4'h5, FR_UA = 4'h6, FR_DM = 4'h7, FR_FRMR = 4'h8, FR_OTHER = 4'h9
  } lfrc_kind_t;
  // one decoded received frame, valid for one cycle
  typedef struct packed {
    logic valid;
    lfrc_kind_t kind;
    logic is_cmd;
    logic pf;
    logic [2:0] nr;
    logic [2:0] ns;
    logic fcs_ok;
    logic too_long;
    logic violation;
  } lfrc_rx_t;
  // one frame request towards the transmitter
  typedef struct packed {
    logic valid;
    lfrc_kind_t kind;
    logic is_cmd;
    logic pf;
    logic w;
    logic z;
  } lfrc_tx_t;
  // whole state of the control block
  typedef struct packed {
    logic [3:0] ctrl;
    logic link_down_prev;
    logic [2:0] na;
    logic [2:0] nb;
    logic [2:0] ne;
    logic [2:0] vr;
    logic [2:0] vs;
    logic local_busy;
    logic remote_busy;
    logic rej_pend;
    logic frmr_cond;
    logic frmr_w;
    logic frmr_z;
    logic reset_wait;
    logic polling;
    logic disc;
    logic p_sabm;
    logic p_ua;
    logic p_frmr;
    logic p_cmd;
    logic p_resp;
    logic p_resp_f;
    logic [T1_W-1:0] t1;
    logic [7:0] n2;
    lfrc_tx_t tx;
    logic store;
    logic [7:0] ack_mask;
    logic ack_irq;
    logic unready_irq;
    logic err_valid;
    logic [7:0] err_code;
    logic tx_hold;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lfrc_state_t;
endpackage

// *** logic/lfrc_ctrl.sv ***
module lfrc_ctrl import lfrc_pkg::*; #(
  parameter int T1_CYCLES = T1_DEFAULT_CYCLES,
  parameter int N2_LIMIT = N2_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // receiver side
  input wire lfrc_rx_t rx,
  // transmitter side
  input wire logic tx_idle,
  input wire logic tx_take,
  input wire logic tx_pkt_done,
  output lfrc_tx_t tx_req,
  output logic tx_hold,
  // memory and host events
  output logic store_en,
  output logic [7:0] ack_mask,
  output logic tx_acknowledged_irq,
  output logic rx_table_unready_irq,
  output logic err_valid,
  output logic [7:0] error_code_field
);
  lfrc_state_t q; // registered state
  lfrc_state_t d; // next state

  // circular window test on a received ack number
  function automatic logic nr_ok(input logic [2:0] nr, input logic [2:0] na, input logic [2:0] nb);
    return 3'(nr - na) <= 3'(nb - na);
  endfunction

  // segments from oldest up to ack number minus one
  function automatic logic [7:0] ack_bits(input logic [2:0] nr, input logic [2:0] na);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = 3'(3'(i) - na) < 3'(nr - na);
    end
    return m;
  endfunction

  // register read mux
  function automatic logic [31:0] rd_mux(input lfrc_state_t s, input logic [7:0] a);
    case (a)
      OFF_CTRL: rd_mux = {28'h000_0000, s.ctrl};
      OFF_STAT: rd_mux = {24'h00_0000, s.disc, s.reset_wait, s.frmr_cond, s.rej_pend,
                          s.remote_busy, s.local_busy, s.polling, s.tx_hold};
      OFF_PTR: rd_mux = {17'h0_0000, s.vs, s.vr, s.ne, s.nb, s.na};
      OFF_ERR: rd_mux = {24'h00_0000, s.err_code};
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  logic ready; // receive memory ready per host
  logic up; // link is up
  logic is_s; // supervisory frame received
  logic nr_good; // received ack number in window
  logic rx_live; // frame taken while link is up
  logic t1_run; // retransmission timer running

  // next-state logic
  always_comb begin
    d = q;
    d.store = 1'b0;
    d.ack_mask = 8'h00;
    d.ack_irq = 1'b0;
    d.unready_irq = 1'b0;
    d.err_valid = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    ready = q.ctrl[CTRL_RX_INIT] & q.ctrl[CTRL_RX_RDY];
    up = !q.ctrl[CTRL_LINK_DOWN];
    is_s = (rx.kind == FR_RR) || (rx.kind == FR_RNR) || (rx.kind == FR_REJ);
    nr_good = nr_ok(rx.nr, q.na, q.nb);
    rx_live = rx.valid && up;
    t1_run = q.remote_busy || (q.na != q.nb);
    d.link_down_prev = q.ctrl[CTRL_LINK_DOWN];
    // apb: setup cycle loads answer, access cycle completes
    if (psel && !penable) begin
      d.pready = 1'b1;
      d.prdata = rd_mux(q, paddr);
      d.pslverr = !(paddr == OFF_CTRL || paddr == OFF_STAT || paddr == OFF_PTR || paddr == OFF_ERR);
    end
    if (psel && penable && q.pready && pwrite && paddr == OFF_CTRL) begin
      d.ctrl = pwdata[3:0];
    end
    // packet handed to the line advances next block
    if (tx_pkt_done && !q.frmr_cond) begin
      d.nb = 3'(q.nb + 3'h1);
    end
    // transmitter request first, so later events re-arm pending flags
    if (up) begin
      if (q.tx.valid) begin
        if (tx_take) begin
          d.tx.valid = 1'b0;
          if (q.tx.kind == FR_SABM) begin
            d.err_valid = q.reset_wait;
            d.err_code = ERR_FRMR_RX;
          end
          if (q.tx.kind == FR_FRMR) begin
            d.frmr_cond = 1'b1;
          end
          if (q.tx.kind == FR_REJ) begin
            d.rej_pend = 1'b0;
          end
        end
      end else if (tx_idle) begin
        d.tx.is_cmd = 1'b0;
        d.tx.pf = 1'b0;
        d.tx.w = q.frmr_w;
        d.tx.z = q.frmr_z;
        // reject only when not busy, rnr while busy
        d.tx.kind = (q.rej_pend && !q.local_busy) ? FR_REJ : (q.local_busy ? FR_RNR : FR_RR);
        d.tx.valid = 1'b1;
        if (q.p_sabm) begin
          d.tx.kind = FR_SABM;
          d.tx.is_cmd = 1'b1;
          d.tx.pf = 1'b1;
          d.p_sabm = 1'b0;
        end else if (q.p_ua) begin
          d.tx.kind = FR_UA;
          d.tx.pf = 1'b1;
          d.p_ua = 1'b0;
        end else if (q.p_frmr) begin
          d.tx.kind = FR_FRMR;
          d.p_frmr = 1'b0;
        end else if (q.p_cmd) begin
          d.tx.is_cmd = 1'b1;
          d.tx.pf = 1'b1;
          d.p_cmd = 1'b0;
        end else if (q.p_resp) begin
          d.tx.pf = q.p_resp_f;
          d.p_resp = 1'b0;
          d.p_resp_f = 1'b0;
        end else begin
          d.tx.valid = 1'b0;
        end
      end
    end
    if (!up) begin
      // link down: drop every pending frame
      d.p_sabm = 1'b0;
      d.p_ua = 1'b0;
      d.p_frmr = 1'b0;
      d.p_cmd = 1'b0;
      d.p_resp = 1'b0;
      d.tx.valid = 1'b0;
      d.t1 = '0;
      d.n2 = 8'h00;
      d.polling = 1'b0;
      d.frmr_cond = 1'b0;
      d.local_busy = 1'b0; // re-tested at link up
      d.reset_wait = 1'b0;
    end else begin
      // not-ready condition, at link up or later
      if (!q.local_busy && !ready && !q.reset_wait) begin // ready: nothing sent
        d.local_busy = 1'b1;
        d.p_resp = 1'b1;
        d.unready_irq = q.ctrl[CTRL_RX_INIT];
      end
      // retransmission timer
      if (!t1_run) begin
        d.t1 = '0;
      end else if (q.t1 == T1_W'(T1_CYCLES - 1)) begin
        d.t1 = '0;
        if (q.n2 == 8'(N2_LIMIT)) begin
          d.p_sabm = 1'b1;
          d.reset_wait = 1'b1;
          d.n2 = 8'h00;
        end else begin
          d.p_cmd = 1'b1;
          d.polling = 1'b1;
          d.n2 = 8'(q.n2 + 8'h01);
        end
      end else begin
        d.t1 = T1_W'(q.t1 + 1'b1);
      end
    end
    // received frame handling
    if (rx_live) begin
      case (rx.kind)
        FR_FRMR: begin
          d.p_sabm = 1'b1;
          d.reset_wait = 1'b1;
          d.ctrl[CTRL_SEND] = 1'b0;
          d.store = !q.local_busy;
          d.local_busy = 1'b1;
        end
        FR_SABM, FR_DISC: begin
          d.p_ua = 1'b1;
          d.frmr_cond = 1'b0;
          d.frmr_w = 1'b0;
          d.frmr_z = 1'b0;
          d.disc = rx.kind == FR_DISC;
          d.local_busy = 1'b0;
          d.rej_pend = 1'b0;
          d.remote_busy = 1'b0;
        end
        FR_UA: begin
          d.remote_busy = 1'b0;
          if (q.reset_wait) begin
            d.na = 3'h0;
            d.nb = 3'h0;
            d.ne = 3'h0;
            d.vr = 3'h0;
            d.vs = 3'h0;
            d.reset_wait = 1'b0;
            d.local_busy = 1'b0;
            d.rej_pend = 1'b0;
            d.polling = 1'b0;
            d.n2 = 8'h00;
            d.disc = 1'b0;
          end else begin
            d.p_frmr = 1'b1;
            d.frmr_w = 1'b1;
          end
        end
        FR_I, FR_RR, FR_RNR, FR_REJ: begin
          if (!nr_good) begin
            d.p_frmr = 1'b1;
            d.frmr_z = 1'b1;
          end else begin
            if (rx.nr != q.na) begin
              d.ack_mask = ack_bits(rx.nr, q.na);
              d.ack_irq = 1'b1;
              d.na = rx.nr;
              d.t1 = '0;
              d.n2 = 8'h00;
            end
            if (q.frmr_cond) begin
              d.p_frmr = 1'b1;
            end
          end
          if (rx.kind == FR_RNR) begin
            d.remote_busy = 1'b1;
          end else if (is_s) begin
            d.remote_busy = 1'b0;
          end
          // poll answered, or final bit unasked
          if (rx.is_cmd && rx.pf) begin
            d.p_resp = 1'b1;
            d.p_resp_f = 1'b1;
          end else if (!rx.is_cmd && rx.pf) begin
            if (q.polling) begin
              d.polling = 1'b0;
              d.n2 = 8'h00;
            end else begin
              d.p_frmr = 1'b1;
              d.frmr_w = 1'b1;
            end
          end
          // busy clears on a packet or command once memory is ready
          if (q.local_busy && ready && (rx.kind == FR_I || rx.is_cmd)) begin
            d.local_busy = 1'b0;
            d.p_resp = 1'b1;
          end
          if (rx.kind == FR_I && rx.fcs_ok && !q.frmr_cond) begin
            if (rx.ns == q.vr) begin
              d.rej_pend = 1'b0;
              if (!rx.too_long && !q.local_busy) begin
                d.store = 1'b1;
                d.vr = 3'(q.vr + 3'h1);
                d.ne = 3'(q.ne + 3'h1);
              end
            end else if (3'(rx.ns + 3'h1) != q.vr) begin
              d.rej_pend = 1'b1;
              d.p_resp = 1'b1;
            end
          end
        end
        default: ; // other frames change nothing here
      endcase
      if (rx.violation) begin
        d.p_frmr = 1'b1;
        d.frmr_w = 1'b1;
      end
    end
    // packets held back by link down, reject state, busy peer or full window
    d.tx_hold = !up || d.frmr_cond || d.remote_busy || (3'(d.nb + 3'h1) == d.na);
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.link_down_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state flops
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign prdata = q.prdata;
  assign tx_req = q.tx;
  assign tx_hold = q.tx_hold;
  assign store_en = q.store;
  assign ack_mask = q.ack_mask;
  assign tx_acknowledged_irq = q.ack_irq;
  assign rx_table_unready_irq = q.unready_irq;
  assign err_valid = q.err_valid;
  assign error_code_field = q.err_code;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_link_down_quiet: assert property (q.ctrl[CTRL_LINK_DOWN] |=> !q.tx.valid)
    else $error("frame requested while link down");
  a_nr_bad_frmr: assert property (rx.valid && up && rx.kind == FR_RR && !nr_good |=> q.p_frmr && q.frmr_z)
    else $error("bad ack number did not raise frame reject");
  a_ack_advance: assert property (rx.valid && up && is_s && nr_good |=> q.na == $past(rx.nr))
    else $error("oldest pointer did not follow ack");
  a_cmd_poll: assert property (q.tx.valid && q.tx.is_cmd |-> q.tx.pf)
    else $error("command sent without poll bit");
  a_busy_no_store: assert property (q.local_busy |=> !q.store)
    else $error("field stored while busy");
  a_sabm_code: assert property (q.tx.valid && q.tx.kind == FR_SABM && tx_take && q.reset_wait && up
    |=> q.err_valid && q.err_code == ERR_FRMR_RX)
    else $error("link reset code not posted");
  a_remote_busy: assert property (rx.valid && up && rx.kind == FR_RNR |=> q.remote_busy)
    else $error("remote busy not set");
  a_unready_irq: assert property (q.unready_irq |-> q.local_busy && $past(q.ctrl[CTRL_RX_INIT]))
    else $error("unready interrupt without busy");
  a_ptr_zero: assert property (rx.valid && up && rx.kind == FR_UA && q.reset_wait
    |=> q.na == 3'h0 && q.ne == 3'h0 && q.vr == 3'h0)
    else $error("pointers not zeroed after reset");
  a_unsolicited: assert property (rx.valid && up && rx.kind == FR_UA && !q.reset_wait
    |=> q.p_frmr && q.frmr_w)
    else $error("unsolicited ua not rejected");
  a_link_up_rnr: assert property (q.link_down_prev && up && !ready && !rx.valid |=> q.local_busy)
    else $error("unready link up left busy clear");
endmodule // lfrc_ctrl

// *** testbench/lfrc_ctrl_tb.sv ***
// top bench: apb tasks, remote model, frame sequences
module lfrc_ctrl_tb import lfrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, perr, slow;
  logic [7:0] paddr, ack_mask, err_code, last_ack;
  logic [31:0] pwdata, prdata, rd;
  lfrc_rx_t rx;
  lfrc_tx_t tx_req, f;
  logic tx_idle, tx_take, tx_pkt_done, tx_hold, store_en, ack_irq, unready_irq, err_valid;
  int fail_count, samples_checked, irq_cnt, store_cnt, err_cnt;
  lfrc_ctrl #(.T1_CYCLES(20), .N2_LIMIT(2)) dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .rx, .tx_idle, .tx_take, .tx_pkt_done, .tx_req, .tx_hold, .store_en,
    .ack_mask, .tx_acknowledged_irq(ack_irq), .rx_table_unready_irq(unready_irq), .err_valid,
    .error_code_field(err_code));
  lfrc_remote far (.clk, .rst, .tx_req, .slow, .rx, .tx_idle, .tx_take, .tx_pkt_done);
  // clock of 5 ns
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // interrupt and ack monitor
  always @(posedge clk) begin
    if (unready_irq === 1'b1) irq_cnt++;
    if (ack_irq === 1'b1) last_ack = ack_mask;
    if (store_en === 1'b1) store_cnt++;
    if (err_valid === 1'b1) err_cnt++;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer, waits for pready
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd & m, exp, what);
  endtask
  // waits for the next frame taken by the remote side
  task expect_tx(input lfrc_kind_t k, input logic cmd, input logic pf);
    int n;
    n = 0;
    while (far.got.size() == 0 && n < 400) begin
      n++;
      @(posedge clk);
    end
    f = (far.got.size() > 0) ? far.got.pop_front() : '0;
    chk(32'({f.valid, f.kind, f.is_cmd, f.pf}), 32'({1'b1, k, cmd, pf}), "sent frame");
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict;
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    slow = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0001, "ctrl reset");
    rchk(OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0001, "stat reset");
    rchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
    chk(32'(perr), 32'h0000_0001, "unmapped error");
    far.send(FR_RR, 1'b1, 1'b1, 3'h0);
    repeat (30) @(posedge clk);
    chk(32'(far.got.size()), 32'h0000_0000, "frame while down");
    apb(1'b1, OFF_CTRL, 32'h0000_0006);
    repeat (30) @(posedge clk);
    chk(32'(far.got.size()), 32'h0000_0000, "frame at ready link up");
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    irq_cnt = 0;
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    expect_tx(FR_RNR, 1'b0, 1'b0);
    chk(32'(irq_cnt), 32'h0000_0001, "unready irq");
    rchk(OFF_STAT, 32'h0000_0004, 32'h0000_0004, "local busy set");
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    irq_cnt = 0;
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    expect_tx(FR_RNR, 1'b0, 1'b0);
    chk(32'(irq_cnt), 32'h0000_0000, "no unready irq");
    apb(1'b1, OFF_CTRL, 32'h0000_0006);
    far.send(FR_RR, 1'b1, 1'b1, 3'h0);
    expect_tx(FR_RR, 1'b0, 1'b1);
    rchk(OFF_STAT, 32'h0000_0004, 32'h0000_0000, "local busy cleared");
    far.pkt(3);
    far.send(FR_RR, 1'b0, 1'b0, 3'h2);
    repeat (2) @(posedge clk);
    chk(32'(last_ack), 32'h0000_0003, "ack mask");
    far.send(FR_RNR, 1'b0, 1'b0, 3'h3);
    rchk(OFF_STAT, 32'h0000_0008, 32'h0000_0008, "remote busy set");
    far.send(FR_RR, 1'b0, 1'b0, 3'h3);
    rchk(OFF_STAT, 32'h0000_0008, 32'h0000_0000, "remote busy cleared");
    rchk(OFF_PTR, 32'h0000_003F, 32'h0000_001B, "na and nb");
    far.got.delete();
    far.send(FR_RR, 1'b0, 1'b0, 3'h4);
    expect_tx(FR_FRMR, 1'b0, 1'b0);
    rchk(OFF_STAT, 32'h0000_0021, 32'h0000_0021, "frmr state holds packets");
    far.send(FR_RR, 1'b0, 1'b0, 3'h3);
    expect_tx(FR_FRMR, 1'b0, 1'b0);
    far.send(FR_RR, 1'b0, 1'b0, 3'h6);
    expect_tx(FR_FRMR, 1'b0, 1'b0);
    chk(32'(f.z), 32'h0000_0001, "frmr z flag");
    far.send(FR_SABM, 1'b1, 1'b1, 3'h0);
    expect_tx(FR_UA, 1'b0, 1'b1);
    rchk(OFF_STAT, 32'h0000_0020, 32'h0000_0000, "frmr state left");
    far.got.delete();
    far.pkt(7);
    far.send(FR_RR, 1'b0, 1'b0, 3'h2);
    repeat (2) @(posedge clk);
    chk(32'(last_ack), 32'h0000_00FB, "full window ack");
    far.got.delete();
    far.pkt(1);
    expect_tx(FR_RR, 1'b1, 1'b1);
    expect_tx(FR_RR, 1'b1, 1'b1);
    expect_tx(FR_SABM, 1'b1, 1'b1);
    far.send(FR_UA, 1'b0, 1'b1, 3'h0);
    rchk(OFF_PTR, 32'h0000_7FFF, 32'h0000_0000, "pointers zeroed");
    slow <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h0000_000E);
    far.got.delete();
    err_cnt = 0;
    store_cnt = 0;
    far.send(FR_FRMR, 1'b0, 1'b0, 3'h0);
    expect_tx(FR_SABM, 1'b1, 1'b1);
    rchk(OFF_ERR, 32'h0000_00FF, 32'(ERR_FRMR_RX), "error code");
    rchk(OFF_CTRL, 32'h0000_0008, 32'h0000_0000, "send cleared");
    chk(32'(err_cnt), 32'h0000_0001, "error pulse");
    chk(32'(store_cnt), 32'h0000_0001, "frmr field stored");
    far.send(FR_UA, 1'b0, 1'b1, 3'h0);
    repeat (10) @(posedge clk);
    far.got.delete();
    far.send(FR_UA, 1'b0, 1'b1, 3'h0);
    expect_tx(FR_FRMR, 1'b0, 1'b0);
    chk(32'(f.w), 32'h0000_0001, "frmr w flag");
    give_verdict;
  end
endmodule // lfrc_ctrl_tb

// *** testbench/lfrc_remote.sv ***
// remote station model: sends decoded frames, takes requested frames
module lfrc_remote import lfrc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link towards the control block
  input wire lfrc_tx_t tx_req,
  input wire logic slow,
  output lfrc_rx_t rx,
  output logic tx_idle,
  output logic tx_take,
  output logic tx_pkt_done
);
  timeunit 1ns;
  timeprecision 1ps;
  lfrc_tx_t got[$]; // frames taken, oldest first
  int wait_n; // cycles a request has waited
  initial begin
    rx = '0;
    tx_idle = 1'b1;
    tx_take = 1'b0;
    tx_pkt_done = 1'b0;
    wait_n = 0;
  end
  // take each request once, at once or after a stall
  always @(posedge clk) begin
    if (rst || !tx_req.valid || tx_take) begin
      tx_take <= 1'b0;
      wait_n <= 0;
    end else if (wait_n >= (slow ? 3 : 0)) begin
      tx_take <= 1'b1;
      got.push_back(tx_req);
    end else begin
      wait_n <= wait_n + 1;
    end
  end
  // one received frame, fields scrambled when idle
  task send(input lfrc_kind_t k, input logic cmd, input logic pf, input logic [2:0] nr);
    @(posedge clk);
    rx <= '{valid: 1'b1, kind: k, is_cmd: cmd, pf: pf, nr: nr, ns: 3'h0, fcs_ok: 1'b1, too_long: 1'b0, violation: 1'b0};
    @(posedge clk);
    rx.valid <= 1'b0;
    rx.nr <= ~nr;
    rx.pf <= ~pf;
  endtask
  // n packets finish back to back
  task pkt(input int n);
    repeat (n) begin
      @(posedge clk);
      tx_pkt_done <= 1'b1;
    end
    @(posedge clk);
    tx_pkt_done <= 1'b0;
  endtask
endmodule // lfrc_remote
